//--- hw/fp_special_operand_nan_logic.sv
// Special operand, NaN result and exception flag logic, APB register front.
// Assumes an APB master on pclk; operations run one at a time.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/10ps

// Overview of operation
// - Fully shifted-out tiny result becomes zero
// - Normalize results whenever the exponent allows
// - Denormal result raises underflow
// - Denormal source operand raises denormal flag
// - Infinity: zero fraction, exponent all ones
// - Compare infinities affinely, sign observed
// - Infinity arithmetic exact; invalid only flags
// - Exponent past maximum gives infinity
// - Max exponent, nonzero fraction is NaN
// - Top fraction bit: quiet one, signaling zero
// - Quiet NaN passes without exception
// - Signaling NaN operand raises invalid
// - Never output a signaling NaN
// - Unmasked invalid on SNaN: destination untouched
// - Quieting sets top fraction bit only
// - Masked SNaN sets invalid, delivers NaN
// - Invalid without NaN gives indefinite
// - SNaN plus QNaN: stack QNaN, vector first
// - Two SNaNs: stack larger, vector first; quieted
// - Two QNaNs: stack larger, vector first
// - NaN with number returns quieted NaN
// - Single operand NaN returned quieted
// - Zero exponent, nonzero fraction is denormal
// - Masked: default result; unmasked: fault
// - One reserved quiet NaN as indefinite
module fp_special_operand_nan_logic (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] ctrl;
    logic [31:0] result;
    logic [fp_special_pkg::FLG_W-1:0] flags;
    logic done;
    fp_special_pkg::state_type state;
    logic setup;
    logic wr_access;
    logic go_write;
    logic [fp_special_pkg::FLG_W-1:0] clr;
    logic [fp_special_pkg::FLG_W-1:0] set;
    logic mapped;
    logic [31:0] read_word;
    fp_special_pkg::op_type op;
    logic vector_policy;
    logic [7:0] shift;
    logic [31:0] next_result;
    logic ev_ie;
    logic ev_de;
    logic ev_ue;
    logic ev_oe;
    logic unmasked_hit;
    logic [31:0] nan_pick;
    logic [31:0] cmp_word;
    logic a_less;
    logic a_equal;
    logic [31:0] scaled;
    logic scale_tiny;
    logic scale_huge;
    fp_class_if cls_a ();
    fp_class_if cls_b ();
    assign cls_a.value = opa;
    assign cls_b.value = opb;
    fp_operand_classifier classify_a (.port(cls_a.classifier));
    fp_operand_classifier classify_b (.port(cls_b.classifier));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] lead_zeros(input logic [23:0] s);
        logic [4:0] n;
        n = 5'(fp_special_pkg::SIG_W);
        for (int i = 0; i < fp_special_pkg::SIG_W; i++) begin
            if (s[i]) begin
                n = 5'(fp_special_pkg::SIG_W - 1 - i);
            end
        end
        return n;
    endfunction : lead_zeros

    // Monotonic key: both zeros equal, negatives below positives
    function automatic logic [31:0] order_key(input logic [31:0] x);
        if (x[30:0] == 31'h00000000) begin
            return 32'h80000000;
        end else if (x[fp_special_pkg::SIGN_BIT]) begin
            return ~x;
        end else begin
            return x | 32'h80000000;
        end
    endfunction : order_key

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign setup = psel && !penable;
    assign wr_access = psel && penable && pready && pwrite;
    assign go_write = wr_access && (paddr == fp_special_pkg::OFF_CTRL)
        && pwdata[fp_special_pkg::CTRL_GO_BIT];
    assign op = fp_special_pkg::op_type'(ctrl[fp_special_pkg::CTRL_OP_LSB +: 2]);
    assign vector_policy = ctrl[fp_special_pkg::CTRL_VECTOR_BIT];
    assign shift = ctrl[fp_special_pkg::CTRL_SHIFT_LSB +: 8];
    always_comb begin
        mapped = 1'b1;
        read_word = 32'h00000000;
        if (paddr == fp_special_pkg::OFF_OPA) begin
            read_word = opa;
        end else if (paddr == fp_special_pkg::OFF_OPB) begin
            read_word = opb;
        end else if (paddr == fp_special_pkg::OFF_CTRL) begin
            read_word = ctrl;
        end else if (paddr == fp_special_pkg::OFF_RESULT) begin
            read_word = result;
        end else if (paddr == fp_special_pkg::OFF_FLAGS) begin
            read_word = {27'h0000000, flags};
        end else if (paddr == fp_special_pkg::OFF_STATUS) begin
            read_word[fp_special_pkg::ST_DONE_BIT] = done;
            read_word[fp_special_pkg::ST_BUSY_BIT] = (state == fp_special_pkg::ST_EXEC);
            read_word[fp_special_pkg::ST_CLS_A_LSB +: 3] = cls_a.cls;
            read_word[fp_special_pkg::ST_CLS_B_LSB +: 3] = cls_b.cls;
        end else begin
            mapped = 1'b0;
        end
    end
    // Answer registered in setup, shown through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            prdata <= (setup && !pwrite) ? read_word : 32'h00000000;
            pslverr <= setup && !mapped;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opa <= 32'h00000000;
            opb <= 32'h00000000;
            ctrl <= fp_special_pkg::CTRL_RESET;
        end else if (wr_access) begin
            if (paddr == fp_special_pkg::OFF_OPA) begin
                opa <= pwdata;
            end else if (paddr == fp_special_pkg::OFF_OPB) begin
                opb <= pwdata;
            end else if (paddr == fp_special_pkg::OFF_CTRL) begin
                ctrl <= pwdata & ~(32'h00000001 << fp_special_pkg::CTRL_GO_BIT);
            end
        end
    end

    // ------------------------------------------------------------
    // Scaling path
    // ------------------------------------------------------------
    always_comb begin
        logic [23:0] sig;
        logic [23:0] sig_n;
        logic [23:0] den;
        logic [4:0] lz;
        logic [10:0] e_eff;
        logic signed [10:0] e_new;
        logic signed [10:0] amt;
        sig = {opa[fp_special_pkg::EXP_MSB:fp_special_pkg::EXP_LSB] != 8'h00,
            opa[fp_special_pkg::FRAC_MSB:0]};
        e_eff = (opa[fp_special_pkg::EXP_MSB:fp_special_pkg::EXP_LSB] == 8'h00)
            ? 11'h001 : {3'h0, opa[fp_special_pkg::EXP_MSB:fp_special_pkg::EXP_LSB]};
        // Leading zeros removed first so a denormal input renormalizes
        lz = lead_zeros(sig);
        sig_n = sig << lz;
        e_new = $signed(e_eff) - $signed({6'h00, lz}) + $signed({{3{shift[7]}}, shift});
        amt = 11'sh001 - e_new;
        den = 24'h000000;
        scale_tiny = 1'b0;
        scale_huge = 1'b0;
        if (e_new >= $signed({3'h0, fp_special_pkg::EXP_MAX})) begin
            scaled = {opa[fp_special_pkg::SIGN_BIT], fp_special_pkg::EXP_MAX, 23'h000000};
            scale_huge = 1'b1;
        end else if (e_new >= 11'sh001) begin
            scaled = {opa[fp_special_pkg::SIGN_BIT], e_new[7:0], sig_n[22:0]};
        end else begin
            if (amt >= 11'sd24) begin
                den = 24'h000000;
            end else begin
                den = sig_n >> amt[4:0];
            end
            scaled = {opa[fp_special_pkg::SIGN_BIT], 8'h00, den[22:0]};
            scale_tiny = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // NaN result choice and affine compare
    // ------------------------------------------------------------
    always_comb begin
        if (cls_a.is_nan && cls_b.is_nan) begin
            if (vector_policy) begin
                nan_pick = cls_a.quieted;
            end else if (cls_a.is_snan != cls_b.is_snan) begin
                nan_pick = cls_a.is_qnan ? opa : opb;
            end else if (opb[fp_special_pkg::FRAC_MSB:0] > opa[fp_special_pkg::FRAC_MSB:0]) begin
                nan_pick = cls_b.quieted;
            end else begin
                nan_pick = cls_a.quieted;
            end
        end else if (cls_a.is_nan) begin
            nan_pick = cls_a.quieted;
        end else begin
            nan_pick = cls_b.quieted;
        end
    end
    assign a_less = order_key(opa) < order_key(opb);
    assign a_equal = order_key(opa) == order_key(opb);
    always_comb begin
        cmp_word = 32'h00000000;
        if (cls_a.is_nan || cls_b.is_nan) begin
            cmp_word[fp_special_pkg::CMP_UN] = 1'b1;
        end else if (a_equal) begin
            cmp_word[fp_special_pkg::CMP_EQ] = 1'b1;
        end else if (a_less) begin
            cmp_word[fp_special_pkg::CMP_LT] = 1'b1;
        end else begin
            cmp_word[fp_special_pkg::CMP_GT] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Operation result and events
    // ------------------------------------------------------------
    always_comb begin
        next_result = result;
        ev_ie = 1'b0;
        ev_de = cls_a.is_denormal;
        ev_ue = 1'b0;
        ev_oe = 1'b0;
        case (op)
            fp_special_pkg::OP_SCALE: begin
                if (cls_a.is_nan) begin
                    next_result = cls_a.quieted;
                    ev_ie = cls_a.is_snan;
                end else if (cls_a.is_inf || cls_a.is_zero) begin
                    next_result = opa;
                end else begin
                    next_result = scaled;
                    ev_ue = scale_tiny;
                    ev_oe = scale_huge;
                end
            end
            fp_special_pkg::OP_COMPARE: begin
                ev_de = cls_a.is_denormal || cls_b.is_denormal;
                ev_ie = cls_a.is_snan || cls_b.is_snan;
                next_result = cmp_word;
            end
            fp_special_pkg::OP_MAX: begin
                ev_de = cls_a.is_denormal || cls_b.is_denormal;
                ev_ie = cls_a.is_snan || cls_b.is_snan;
                if (cls_a.is_nan || cls_b.is_nan) begin
                    next_result = nan_pick;
                end else begin
                    next_result = a_less ? opb : opa;
                end
            end
            default: begin
                ev_de = cls_a.is_denormal || cls_b.is_denormal;
                ev_ie = cls_a.is_snan || cls_b.is_snan;
                if (cls_a.is_nan || cls_b.is_nan) begin
                    next_result = nan_pick;
                end else if (cls_a.is_inf && cls_b.is_inf
                        && (opa[fp_special_pkg::SIGN_BIT] != opb[fp_special_pkg::SIGN_BIT])) begin
                    next_result = fp_special_pkg::INDEFINITE;
                    ev_ie = 1'b1;
                end else if (cls_a.is_inf) begin
                    next_result = opa;
                end else if (cls_b.is_inf) begin
                    next_result = opb;
                end else begin
                    next_result = opa;
                end
            end
        endcase
    end
    // Any unmasked event blocks the write and raises the fault bit
    assign unmasked_hit = (ev_ie && !ctrl[fp_special_pkg::CTRL_IM_BIT])
        || (ev_de && !ctrl[fp_special_pkg::CTRL_DM_BIT])
        || (ev_ue && !ctrl[fp_special_pkg::CTRL_UM_BIT])
        || (ev_oe && !ctrl[fp_special_pkg::CTRL_OM_BIT]);

    // ------------------------------------------------------------
    // Sequencer, result and sticky flags
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= fp_special_pkg::ST_IDLE;
        end else begin
            case (state)
                fp_special_pkg::ST_IDLE: begin
                    if (go_write) begin
                        state <= fp_special_pkg::ST_EXEC;
                    end
                end
                default: begin
                    state <= fp_special_pkg::ST_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= 32'h00000000;
        end else if (state == fp_special_pkg::ST_EXEC && !unmasked_hit) begin
            result <= next_result;
        end
    end
    always_comb begin
        set = '0;
        if (state == fp_special_pkg::ST_EXEC) begin
            set[fp_special_pkg::FLG_IE] = ev_ie;
            set[fp_special_pkg::FLG_DE] = ev_de;
            set[fp_special_pkg::FLG_UE] = ev_ue;
            set[fp_special_pkg::FLG_OE] = ev_oe;
            set[fp_special_pkg::FLG_FAULT] = unmasked_hit;
        end
        clr = '0;
        if (wr_access && paddr == fp_special_pkg::OFF_FLAGS) begin
            clr = pwdata[fp_special_pkg::FLG_W-1:0];
        end
    end
    // Set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clr) | set;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
        end else if (state == fp_special_pkg::ST_EXEC) begin
            done <= 1'b1;
        end else if (go_write) begin
            done <= 1'b0;
        end
    end
endmodule : fp_special_operand_nan_logic

//--- hw/fp_special_pkg.sv
// Constants, field layout and types for the special-operand logic.
// Assumes IEEE single precision operands and a 32-bit APB register bus.
package fp_special_pkg;

    // ------------------------------------------------------------
    // Operand format
    // ------------------------------------------------------------
    localparam int SIGN_BIT = 31;
    localparam int EXP_MSB = 30;
    localparam int EXP_LSB = 23;
    localparam int FRAC_MSB = 22;
    localparam int SIG_W = 24;
    localparam logic [7:0] EXP_MAX = 8'hFF;
    localparam logic [31:0] QUIET_MASK = 32'h00400000;
    localparam logic [31:0] INDEFINITE = 32'hFFC00000;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_OPA = 8'h00;
    localparam logic [7:0] OFF_OPB = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_RESULT = 8'h0C;
    localparam logic [7:0] OFF_FLAGS = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_VECTOR_BIT = 2;
    localparam int CTRL_IM_BIT = 4;
    localparam int CTRL_DM_BIT = 5;
    localparam int CTRL_UM_BIT = 6;
    localparam int CTRL_OM_BIT = 7;
    localparam int CTRL_SHIFT_LSB = 8;
    localparam int CTRL_GO_BIT = 31;
    localparam logic [31:0] CTRL_RESET = 32'h000000F0;

    // ------------------------------------------------------------
    // Flag, status and compare fields
    // ------------------------------------------------------------
    localparam int FLG_IE = 0;
    localparam int FLG_DE = 1;
    localparam int FLG_UE = 2;
    localparam int FLG_OE = 3;
    localparam int FLG_FAULT = 4;
    localparam int FLG_W = 5;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_CLS_A_LSB = 8;
    localparam int ST_CLS_B_LSB = 12;
    localparam int CMP_LT = 0;
    localparam int CMP_EQ = 1;
    localparam int CMP_GT = 2;
    localparam int CMP_UN = 3;

    localparam logic [2:0] CLS_ZERO = 3'h0;
    localparam logic [2:0] CLS_NORMAL = 3'h1;
    localparam logic [2:0] CLS_DENORMAL = 3'h2;
    localparam logic [2:0] CLS_INF = 3'h3;
    localparam logic [2:0] CLS_QNAN = 3'h4;
    localparam logic [2:0] CLS_SNAN = 3'h5;

    typedef enum logic [1:0] {OP_SCALE, OP_COMPARE, OP_MAX, OP_INF_SUM} op_type;
    typedef enum logic {ST_IDLE, ST_EXEC} state_type;

endpackage : fp_special_pkg

//--- hw/fp_class_if.sv
// Carrier between the operand classifier and the main logic.
// Assumes one instance per operand.
`timescale 1ns/10ps
interface fp_class_if;
    logic [31:0] value;
    logic is_zero;
    logic is_denormal;
    logic is_inf;
    logic is_nan;
    logic is_qnan;
    logic is_snan;
    logic [2:0] cls;
    logic [31:0] quieted;

    modport classifier (input value, output is_zero, is_denormal, is_inf,
        is_nan, is_qnan, is_snan, cls, quieted);
    modport user (output value, input is_zero, is_denormal, is_inf,
        is_nan, is_qnan, is_snan, cls, quieted);
endinterface : fp_class_if

//--- hw/fp_operand_classifier.sv
// Purely combinational class decode of one single precision operand.
// Assumes the value is held stable by the owner of the interface.
`timescale 1ns/10ps
module fp_operand_classifier (
    fp_class_if.classifier port
);
    logic [7:0] expo;
    logic [22:0] frac;
    logic exp_max;
    logic frac_zero;

    assign expo = port.value[fp_special_pkg::EXP_MSB:fp_special_pkg::EXP_LSB];
    assign frac = port.value[fp_special_pkg::FRAC_MSB:0];
    assign exp_max = (expo == fp_special_pkg::EXP_MAX);
    assign frac_zero = (frac == 23'h000000);

    assign port.is_zero = (expo == 8'h00) && frac_zero;
    assign port.is_denormal = (expo == 8'h00) && !frac_zero;
    assign port.is_inf = exp_max && frac_zero;
    assign port.is_nan = exp_max && !frac_zero;
    assign port.is_qnan = port.is_nan && frac[fp_special_pkg::FRAC_MSB];
    assign port.is_snan = port.is_nan && !frac[fp_special_pkg::FRAC_MSB];

    // Top fraction bit forced, all else kept
    assign port.quieted = port.value | fp_special_pkg::QUIET_MASK;

    always_comb begin
        if (port.is_zero) begin
            port.cls = fp_special_pkg::CLS_ZERO;
        end else if (port.is_denormal) begin
            port.cls = fp_special_pkg::CLS_DENORMAL;
        end else if (port.is_inf) begin
            port.cls = fp_special_pkg::CLS_INF;
        end else if (port.is_qnan) begin
            port.cls = fp_special_pkg::CLS_QNAN;
        end else if (port.is_snan) begin
            port.cls = fp_special_pkg::CLS_SNAN;
        end else begin
            port.cls = fp_special_pkg::CLS_NORMAL;
        end
    end

endmodule : fp_operand_classifier

//--- bench/fp_special_sva.sv
// Checker of the APB answer timing and of encodings seen on read data.
// Assumes it is bound to fp_special_operand_nan_logic.
`timescale 1ns/10ps
module fp_special_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic rd;
    assign rd = pready && !pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_setup_a: assert property (psel && !penable |=> pready && penable)
        else $error("no answer after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (pready && paddr > 8'h14 |-> pslverr)
        else $error("unmapped address accepted");
    mapped_ok_a: assert property (pready && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped address refused");
    go_reads_zero_a: assert property (rd && paddr == fp_special_pkg::OFF_CTRL |-> !prdata[31])
        else $error("go bit reads back");
    no_snan_out_a: assert property (rd && paddr == fp_special_pkg::OFF_RESULT
        && prdata[30:23] == 8'hFF && prdata[22:0] != 23'h0 |-> prdata[22])
        else $error("signaling result");
    class_code_a: assert property (rd && paddr == fp_special_pkg::OFF_STATUS
        |-> prdata[10:8] <= 3'h5 && prdata[14:12] <= 3'h5)
        else $error("bad class code");
endmodule : fp_special_sva

bind fp_special_operand_nan_logic fp_special_sva chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

//--- bench/apb_pipeline_model.sv
// APB master standing in for the execution pipeline.
// Assumes any number of wait states; the bench timeout bounds a wait.
`timescale 1ns/10ps
module apb_pipeline_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released address and data show the inverse, never a stale value; pwrite keeps its last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : apb_pipeline_model

//--- bench/fp_special_operand_nan_logic_tb.sv
// Self-checking bench: reset values, bus errors, operand classes,
// NaN result choice, special results and flags.
// Assumes apb_pipeline_model drives the register bus.
`timescale 1ns/10ps
module fp_special_operand_nan_logic_tb;
    typedef struct {logic [31:0] a, b, c, r, f;} vec_type;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, va, vb;
    logic pol;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [31:0] cls_vals[$] = '{32'h80000000, 32'h3F800000, 32'h00000001,
        32'hFF800000, 32'h7FC00000, 32'h7F800001};
    vec_type tbl[13] = '{
        '{32'h0D800000, 32'h0, 32'h80009CF0, 32'h0, 32'h4},
        '{32'h3F800000, 32'h0, 32'h800080F0, 32'h00200000, 32'h4},
        '{32'h00400000, 32'h0, 32'h80000AF0, 32'h05000000, 32'h2},
        '{32'h71800000, 32'h0, 32'h800064F0, 32'h7F800000, 32'h8},
        '{32'h7F800001, 32'h0, 32'h800000F0, 32'h7FC00001, 32'h1},
        '{32'hFFC01234, 32'h0, 32'h800000F0, 32'hFFC01234, 32'h0},
        '{32'h7F800000, 32'hFF800000, 32'h800000F3, 32'hFFC00000, 32'h1},
        '{32'hFF800000, 32'h3F800000, 32'h800000F3, 32'hFF800000, 32'h0},
        '{32'hFF800000, 32'hC7000000, 32'h800000F1, 32'h1, 32'h0},
        '{32'h7F800000, 32'h7F7FFFFF, 32'h800000F1, 32'h4, 32'h0},
        '{32'h7F800001, 32'hFF800001, 32'h800000F2, 32'h7FC00001, 32'h1},
        '{32'h7F800002, 32'h3F800000, 32'h800000E2, 32'h7FC00001, 32'h11},
        '{32'h3F800000, 32'h0, 32'h800080B0, 32'h7FC00001, 32'h14}};

    always #25 pclk = ~pclk;
    fp_special_operand_nan_logic uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr);
    apb_pipeline_model mst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic logic is_nan(input logic [31:0] x);
        return x[30:23] == 8'hFF && x[22:0] != 23'h0;
    endfunction : is_nan
    function automatic logic is_snan(input logic [31:0] x);
        return is_nan(x) && !x[22];
    endfunction : is_snan
    function automatic logic [31:0] nan_pick(input logic [31:0] a, b, input logic v);
        if (!is_nan(a))
            return b | fp_special_pkg::QUIET_MASK;
        if (!is_nan(b) || v)
            return a | fp_special_pkg::QUIET_MASK;
        if (is_snan(a) != is_snan(b))
            return is_snan(a) ? b : a;
        return ((b[22:0] > a[22:0]) ? b : a) | fp_special_pkg::QUIET_MASK;
    endfunction : nan_pick
    function automatic logic [2:0] cls_of(input logic [31:0] x);
        if (x[30:23] == 8'hFF)
            return (x[22:0] == 23'h0) ? 3'h3 : (x[22] ? 3'h4 : 3'h5);
        if (x[30:23] == 8'h0)
            return (x[22:0] == 23'h0) ? 3'h0 : 3'h2;
        return 3'h1;
    endfunction : cls_of
    function automatic logic [31:0] rnd_val(input int k);
        logic [31:0] s;
        s = $urandom;
        if (k == 0)
            return {s[31], 2'h2, s[28:0]};
        return {s[31], 8'hFF, k == 1, s[21:1], 1'b1};
    endfunction : rnd_val

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t word %h want %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_err(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t bus error %b want %b", $time, got, exp);
        end
    endtask : chk_err
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        mst.xfer(1'b1, a, d, rd, err);
        chk_err(err, 1'b0);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        mst.xfer(1'b0, a, 32'h0, rd, err);
        chk_word(rd, exp);
    endtask : rd_chk
    task automatic op(input vec_type t);
        wr(fp_special_pkg::OFF_FLAGS, 32'h1F);
        wr(fp_special_pkg::OFF_OPA, t.a);
        wr(fp_special_pkg::OFF_OPB, t.b);
        wr(fp_special_pkg::OFF_CTRL, t.c);
        rd_chk(fp_special_pkg::OFF_RESULT, t.r);
        rd_chk(fp_special_pkg::OFF_FLAGS, t.f);
    endtask : op

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hC5D66979));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(fp_special_pkg::OFF_CTRL, fp_special_pkg::CTRL_RESET);
        rd_chk(fp_special_pkg::OFF_FLAGS, 32'h0);
        rd_chk(fp_special_pkg::OFF_RESULT, 32'h0);
        mst.xfer(1'b0, 8'h18, 32'h0, rd, err);
        chk_err(err, 1'b1);
        foreach (cls_vals[i]) begin
            wr(fp_special_pkg::OFF_OPA, cls_vals[i]);
            wr(fp_special_pkg::OFF_OPB, cls_vals[5 - i]);
            wr(fp_special_pkg::OFF_CTRL, 32'h800000F1);
            rd_chk(fp_special_pkg::OFF_STATUS, {17'h0, cls_of(cls_vals[5 - i]), 1'b0,
                cls_of(cls_vals[i]), 8'h1});
        end
        foreach (tbl[i])
            op(tbl[i]);
        repeat (16) begin
            va = rnd_val($urandom_range(2));
            vb = rnd_val($urandom_range(2));
            if (!is_nan(va) && !is_nan(vb))
                vb = rnd_val(1);
            pol = $urandom_range(1);
            op('{va, vb, 32'h800000F2 | {29'h0, pol, 2'h0}, nan_pick(va, vb, pol),
                {31'h0, is_snan(va) || is_snan(vb)}});
        end
        wr(fp_special_pkg::OFF_FLAGS, 32'h1F);
        rd_chk(fp_special_pkg::OFF_FLAGS, 32'h0);
        finish_test();
    end
endmodule : fp_special_operand_nan_logic_tb
